/* File: rtl/frrpr_pkg.sv */
// shared constants, table image and types for both link ends
package frrpr_pkg;
	// timing
	localparam int CLK_NS          = 10;
	localparam int LINK_PERIOD_NS  = 80;
	localparam int SCLK_HALF_CYC   = LINK_PERIOD_NS / (2 * CLK_NS);
	localparam int CS_HIGH_CYC     = 2 * SCLK_HALF_CYC;
	localparam int RESUME_GAP_NS   = 1000000;
	localparam int RESUME_GAP_CYC  = (RESUME_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECOV_IDLE_NS   = 20000;
	localparam int RECOV_IDLE_CYC  = (RECOV_IDLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECOV_WRITE_NS  = 30000;
	localparam int RECOV_WRITE_CYC = (RECOV_WRITE_NS + CLK_NS - 1) / CLK_NS;
	localparam int OP_TIME_NS      = 5000;
	localparam int OP_CYC          = (OP_TIME_NS + CLK_NS - 1) / CLK_NS;
	// opcodes
	localparam logic [7:0] OP_RESUME          = 8'h30;
	localparam logic [7:0] OP_NOP             = 8'h00;
	localparam logic [7:0] OP_RESET_ARM       = 8'h66;
	localparam logic [7:0] OP_RESET           = 8'h99;
	localparam logic [7:0] OP_TABLE_READ      = 8'h5a;
	localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_SUSPEND         = 8'hb0;
	// frame layout, counted in clock periods of the link
	localparam logic [6:0] SPI_CMD_BITS     = 7'h08;
	localparam logic [6:0] QUAD_CMD_NIBBLES = 7'h02;
	localparam logic [6:0] ADDR_END         = 7'h20;
	localparam logic [6:0] TABLE_DATA_START = 7'h28;
	localparam logic [6:0] TABLE_TOTAL      = 7'h48;
	localparam logic [7:0] DUMMY_BYTE       = 8'h00;
	localparam int         SI_LINE          = 0;
	localparam int         SO_LINE          = 1;
	// header table image
	localparam logic [7:0] VENDOR_ID   = 8'h5e; // arbitrary value
	localparam logic [7:0] UNUSED_BYTE = 8'hff;
	localparam int         TABLE_LEN   = 24;
	localparam logic [7:0] HDR_TABLE [0:TABLE_LEN-1] = '{
		8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff,
		8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff,
		VENDOR_ID, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hff};
	// controller registers on apb
	localparam int         APB_ADDR_W    = 8;
	localparam logic [7:0] REG_CMD       = 8'h00;
	localparam logic [7:0] REG_ADDR      = 8'h04;
	localparam logic [7:0] REG_STATUS    = 8'h08;
	localparam logic [7:0] REG_RDATA     = 8'h0c;
	localparam int         CMD_QUAD_BIT  = 8;
	localparam int         CMD_TABLE_BIT = 9;
	localparam int         STAT_BUSY_BIT = 0;
	localparam int         STAT_HOLD_BIT = 1;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_LOW  = 2'b01,
		H_HIGH = 2'b10,
		H_END  = 2'b11
	} frrpr_hstate_t;
endpackage

/* File: rtl/frrpr_link_if.sv */
// serial link between controller and flash device
`timescale 1ns/10ps
interface frrpr_link_if;
	logic       cs_n;
	logic       sclk;
	logic [3:0] host_io_o;
	logic [3:0] host_io_oe_n;
	logic [3:0] dev_io_o;
	logic [3:0] dev_io_oe_n;
	logic [3:0] io;

	// pulled up when nobody drives
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (!dev_io_oe_n[i])
				io[i] = dev_io_o[i];
			else if (!host_io_oe_n[i])
				io[i] = host_io_o[i];
			else
				io[i] = 1'b1;
		end
	end

	modport host (output cs_n, output sclk, output host_io_o, output host_io_oe_n, input io);
	modport dev  (input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe_n);
endinterface

/* File: rtl/frrpr_device.sv */
// flash device end: resume, nop, software reset and header table read
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
// Function
// - resume opcode continues suspended write
// - resume clears the set suspend flag
// - busy held during write, cleared on completion
// - host may wait full operation time
// - resume needs no write latch
// - host waits 1ms before next suspend
// - resume ignored while performance mode on
// - nop only cancels armed reset
// - opcode: 8 single-line or 2 quad clocks
// - reset only straight after reset arm
// - reset restores all power-on defaults
// - reset aborts program or erase
// - host waits recovery time after reset
// - table read: opcode, address, dummy, data
// - chip select high stops data drive
// - byte 06h holds header count 01h
// - first header: id, revision, length, pointer
// - second header: vendor id, 04h, 000060h
// - suspend clears latch, limits commands
module frrpr_device #(
	parameter int OP_CYC          = frrpr_pkg::OP_CYC,
	parameter int RECOV_IDLE_CYC  = frrpr_pkg::RECOV_IDLE_CYC,
	parameter int RECOV_WRITE_CYC = frrpr_pkg::RECOV_WRITE_CYC
) (
	input  logic             clk,
	input  logic             rst_n,
	input  logic             ce,
	frrpr_link_if.dev        link,
	input  logic             start_erase,
	input  logic             start_program,
	input  logic             suspend,
	input  logic             quad_enter,
	input  logic             quad_exit,
	input  logic             perf_enter,
	input  logic             perf_exit,
	output logic             busy_flag,
	output logic             erase_suspended_flag,
	output logic             program_suspended_flag,
	output logic             write_latch_flag,
	output logic             quad_command_mode,
	output logic             perf_mode,
	output logic             write_done
);

	typedef struct packed {
		logic        sclk_m;
		logic        sclk_s;
		logic        sclk_p;
		logic        cs_m;
		logic        cs_s;
		logic        cs_p;
		logic [3:0]  io_m;
		logic [3:0]  io_s;
		logic [6:0]  cnt;
		logic [7:0]  op;
		logic [23:0] taddr;
		logic [2:0]  oidx;
		logic [7:0]  osh;
		logic        so;
		logic        so_oe_n;
		logic        arm;
		logic        quad;
		logic        perf;
		logic        wlatch;
		logic        busy;
		logic        prog;
		logic        esf;
		logic        psf;
		logic [15:0] opc;
		logic [15:0] rec;
		logic        done;
	} frrpr_dev_state_t;

	localparam frrpr_dev_state_t DEV_RESET = '{
		cs_m: 1'b1, cs_s: 1'b1, cs_p: 1'b1, so_oe_n: 1'b1, default: '0};

	frrpr_dev_state_t q;
	frrpr_dev_state_t d;
	logic             rise;
	logic             fall;
	logic             cs_rise;
	logic             cs_fall;
	logic             recov;
	logic             data_phase;
	logic             exact;
	logic [6:0]       need;
	logic [7:0]       cur;

	// header table lookup, out-of-range bytes read as unused
	function automatic logic [7:0] table_byte(input logic [23:0] a);
		if (a < 24'(frrpr_pkg::TABLE_LEN))
			return frrpr_pkg::HDR_TABLE[a[4:0]];
		return frrpr_pkg::UNUSED_BYTE;
	endfunction

	always_comb begin
		d = q;
		d.done = 1'b0;
		cur = '0;
		exact = 1'b0;
		// synchronisers and edge finders
		d.sclk_m = link.sclk;
		d.sclk_s = q.sclk_m;
		d.sclk_p = q.sclk_s;
		d.cs_m = link.cs_n;
		d.cs_s = q.cs_m;
		d.cs_p = q.cs_s;
		d.io_m = link.io;
		d.io_s = q.io_m;
		rise = q.sclk_s & ~q.sclk_p;
		fall = ~q.sclk_s & q.sclk_p;
		cs_rise = q.cs_s & ~q.cs_p;
		cs_fall = ~q.cs_s & q.cs_p;
		need = q.quad ? frrpr_pkg::QUAD_CMD_NIBBLES : frrpr_pkg::SPI_CMD_BITS;
		recov = (q.rec != '0);
		data_phase = ~q.quad & ~recov & (q.op == frrpr_pkg::OP_TABLE_READ)
			& (q.cnt >= frrpr_pkg::TABLE_DATA_START);

		// internal write and reset recovery timing
		if (recov) begin
			d.rec = q.rec - 16'(1);
			if (d.rec == '0)
				d.busy = 1'b0;
		end else if (q.busy) begin
			if (q.opc == '0) begin
				d.busy = 1'b0;
				d.done = 1'b1;
				d.wlatch = 1'b0;
			end else begin
				d.opc = q.opc - 16'(1);
			end
		end

		// write start refused while suspended or busy
		if ((start_erase | start_program) & ~q.busy & ~q.esf & ~q.psf & q.wlatch & ~recov) begin
			d.busy = 1'b1;
			d.prog = start_program;
			d.opc = 16'(OP_CYC - 1);
		end
		if (suspend & q.busy & ~recov & ~d.done) begin
			d.busy = 1'b0;
			d.esf = ~q.prog;
			d.psf = q.prog;
			d.wlatch = 1'b0;
		end
		if (quad_enter)
			d.quad = 1'b1;
		if (quad_exit)
			d.quad = 1'b0;
		if (perf_enter)
			d.perf = 1'b1;
		if (perf_exit)
			d.perf = 1'b0;

		// frame start
		if (cs_fall) begin
			d.cnt = '0;
			d.op = '0;
			d.oidx = '0;
			d.so_oe_n = 1'b1;
		end

		// sample on rising link clock
		if (~q.cs_s & rise) begin
			if (q.cnt < need) begin
				if (q.quad)
					d.op = {q.op[3:0], q.io_s};
				else
					d.op = {q.op[6:0], q.io_s[frrpr_pkg::SI_LINE]};
			end else if (~q.quad & (q.cnt < frrpr_pkg::ADDR_END)) begin
				d.taddr = {q.taddr[22:0], q.io_s[frrpr_pkg::SI_LINE]};
			end
			if (q.cnt != '1)
				d.cnt = q.cnt + 7'(1);
		end

		// shift table bytes out on falling link clock
		if (~q.cs_s & fall & data_phase) begin
			d.so_oe_n = 1'b0;
			d.oidx = q.oidx + 3'(1);
			if (q.oidx == '0) begin
				cur = table_byte(q.taddr);
				d.so = cur[7];
				d.osh = {cur[6:0], 1'b0};
				d.taddr = q.taddr + 24'(1);
			end else begin
				d.so = q.osh[7];
				d.osh = {q.osh[6:0], 1'b0};
			end
		end

		// frame end executes a whole command
		if (cs_rise) begin
			d.so_oe_n = 1'b1;
			if (~recov & (q.cnt >= need)) begin
				exact = (q.cnt == need);
				d.arm = exact & (q.op == frrpr_pkg::OP_RESET_ARM);
				if (exact) begin
					unique case (q.op)
						frrpr_pkg::OP_RESET: begin
							if (q.arm) begin
								d.rec = (q.busy | q.esf | q.psf) ?
									16'(RECOV_WRITE_CYC) : 16'(RECOV_IDLE_CYC);
								d.busy = 1'b1;
								d.opc = '0;
								d.prog = 1'b0;
								d.esf = 1'b0;
								d.psf = 1'b0;
								d.wlatch = 1'b0;
								d.quad = 1'b0;
								d.perf = 1'b0;
								d.arm = 1'b0;
							end
						end
						frrpr_pkg::OP_RESUME: begin
							if (~q.perf & (q.esf | q.psf)) begin
								d.esf = 1'b0;
								d.psf = 1'b0;
								d.busy = 1'b1;
							end
						end
						frrpr_pkg::OP_WRITE_LATCH_SET: d.wlatch = 1'b1;
						default: ;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			q <= DEV_RESET;
		else if (ce)
			q <= d;
	end

	always_comb begin
		link.dev_io_o = '0;
		link.dev_io_oe_n = '1;
		link.dev_io_o[frrpr_pkg::SO_LINE] = q.so;
		link.dev_io_oe_n[frrpr_pkg::SO_LINE] = q.so_oe_n;
	end

	assign busy_flag              = q.busy;
	assign erase_suspended_flag   = q.esf;
	assign program_suspended_flag = q.psf;
	assign write_latch_flag       = q.wlatch;
	assign quad_command_mode      = q.quad;
	assign perf_mode              = q.perf;
	assign write_done             = q.done;

endmodule // frrpr_device

/* File: rtl/frrpr_host.sv */
// controller end: apb command registers driving the serial link
`timescale 1ns/10ps
module frrpr_host #(
	parameter int SCLK_HALF_CYC  = frrpr_pkg::SCLK_HALF_CYC,
	parameter int RESUME_GAP_CYC = frrpr_pkg::RESUME_GAP_CYC,
	parameter int RECOVERY_CYC   = frrpr_pkg::RECOV_WRITE_CYC
) (
	input  logic                            clk,
	input  logic                            rst_n,
	input  logic                            ce,
	input  logic                            psel,
	input  logic                            penable,
	input  logic                            pwrite,
	input  logic [frrpr_pkg::APB_ADDR_W-1:0] paddr,
	input  logic [31:0]                     pwdata,
	output logic [31:0]                     prdata,
	output logic                            pready,
	output logic                            pslverr,
	frrpr_link_if.host                      link
);

	typedef struct packed {
		frrpr_pkg::frrpr_hstate_t st;
		logic        cs_n;
		logic        sclk;
		logic [3:0]  io_o;
		logic [3:0]  oe_n;
		logic        io_m;
		logic        io_s;
		logic [7:0]  div;
		logic [6:0]  bitn;
		logic [6:0]  total;
		logic [39:0] tx;
		logic [31:0] rsh;
		logic [31:0] rdata;
		logic [7:0]  op;
		logic        quad;
		logic        tbl;
		logic [23:0] addr;
		logic        pend;
		logic [19:0] gap;
		logic [15:0] rec;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} frrpr_host_state_t;

	localparam frrpr_host_state_t HOST_RESET = '{
		st: frrpr_pkg::H_IDLE, cs_n: 1'b1, oe_n: 4'hf, default: '0};

	frrpr_host_state_t q;
	frrpr_host_state_t d;
	logic              busy;
	logic              mapped;
	logic              refused;
	logic [6:0]        nbit;
	logic [31:0]       rd;

	// pins for the next clock period of a frame
	function automatic void drive(input logic [39:0] tx, input logic quad,
			output logic [3:0] io, output logic [3:0] oe_n);
		io = 4'hf;
		oe_n = 4'hf;
		if (quad) begin
			io = tx[39:36];
			oe_n = '0;
		end else begin
			io[frrpr_pkg::SI_LINE] = tx[39];
			oe_n[frrpr_pkg::SI_LINE] = 1'b0;
		end
	endfunction

	always_comb begin
		d = q;
		d.io_m = link.io[frrpr_pkg::SO_LINE];
		d.io_s = q.io_m;
		busy = q.pend | (q.st != frrpr_pkg::H_IDLE);
		mapped = (paddr == frrpr_pkg::REG_CMD) | (paddr == frrpr_pkg::REG_ADDR)
			| (paddr == frrpr_pkg::REG_STATUS) | (paddr == frrpr_pkg::REG_RDATA);
		refused = pwrite & (paddr == frrpr_pkg::REG_CMD) & busy;
		nbit = q.bitn + 7'(1);
		rd = '0;
		if (q.gap != '0)
			d.gap = q.gap - 20'(1);
		if (q.rec != '0)
			d.rec = q.rec - 16'(1);

		// apb slave, answers in the first access cycle
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		if (psel & ~penable) begin
			unique case (paddr)
				frrpr_pkg::REG_CMD: begin
					rd[7:0] = q.op;
					rd[frrpr_pkg::CMD_QUAD_BIT] = q.quad;
					rd[frrpr_pkg::CMD_TABLE_BIT] = q.tbl;
				end
				frrpr_pkg::REG_ADDR: rd[23:0] = q.addr;
				frrpr_pkg::REG_STATUS: begin
					rd[frrpr_pkg::STAT_BUSY_BIT] = busy;
					rd[frrpr_pkg::STAT_HOLD_BIT] = (q.gap != '0) | (q.rec != '0);
				end
				frrpr_pkg::REG_RDATA: rd = q.rdata;
				default: rd = '0;
			endcase
			d.pready = 1'b1;
			d.prdata = rd;
			d.pslverr = ~mapped | refused;
		end
		if (psel & penable & q.pready & pwrite & ~q.pslverr) begin
			if (paddr == frrpr_pkg::REG_CMD) begin
				d.pend = 1'b1;
				d.op = pwdata[7:0];
				d.quad = pwdata[frrpr_pkg::CMD_QUAD_BIT];
				d.tbl = pwdata[frrpr_pkg::CMD_TABLE_BIT];
			end
			if (paddr == frrpr_pkg::REG_ADDR)
				d.addr = pwdata[23:0];
		end

		// frame engine, link clock from a divider
		unique case (q.st)
			frrpr_pkg::H_IDLE: begin
				if (q.pend & (q.rec == '0)
						& ~((q.op == frrpr_pkg::OP_SUSPEND) & (q.gap != '0))) begin
					d.pend = 1'b0;
					d.cs_n = 1'b0;
					d.quad = q.quad & ~q.tbl;
					d.tx = {q.op, q.addr, frrpr_pkg::DUMMY_BYTE};
					d.total = q.tbl ? frrpr_pkg::TABLE_TOTAL :
						(d.quad ? frrpr_pkg::QUAD_CMD_NIBBLES : frrpr_pkg::SPI_CMD_BITS);
					d.bitn = '0;
					d.div = 8'(SCLK_HALF_CYC - 1);
					drive(d.tx, d.quad, d.io_o, d.oe_n);
					d.st = frrpr_pkg::H_LOW;
				end
			end
			frrpr_pkg::H_LOW: begin
				if (q.div == '0) begin
					d.sclk = 1'b1;
					d.div = 8'(SCLK_HALF_CYC - 1);
					d.st = frrpr_pkg::H_HIGH;
				end else begin
					d.div = q.div - 8'(1);
				end
			end
			frrpr_pkg::H_HIGH: begin
				if (q.div == '0) begin
					d.sclk = 1'b0;
					d.div = 8'(SCLK_HALF_CYC - 1);
					d.bitn = nbit;
					if (q.bitn >= frrpr_pkg::TABLE_DATA_START)
						d.rsh = {q.rsh[30:0], q.io_s};
					d.tx = q.quad ? {q.tx[35:0], 4'h0} : {q.tx[38:0], 1'b0};
					drive(d.tx, q.quad, d.io_o, d.oe_n);
					if (nbit >= frrpr_pkg::TABLE_DATA_START)
						d.oe_n = 4'hf;
					d.st = (nbit == q.total) ? frrpr_pkg::H_END : frrpr_pkg::H_LOW;
				end else begin
					d.div = q.div - 8'(1);
				end
			end
			frrpr_pkg::H_END: begin
				if (q.div == '0) begin
					d.cs_n = 1'b1;
					d.oe_n = 4'hf;
					d.st = frrpr_pkg::H_IDLE;
					d.rec = (q.op == frrpr_pkg::OP_RESET) ?
						16'(RECOVERY_CYC) : 16'(frrpr_pkg::CS_HIGH_CYC);
					if (q.op == frrpr_pkg::OP_RESUME)
						d.gap = 20'(RESUME_GAP_CYC);
					if (q.tbl)
						d.rdata = {q.rsh[7:0], q.rsh[15:8], q.rsh[23:16], q.rsh[31:24]};
				end else begin
					d.div = q.div - 8'(1);
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			q <= HOST_RESET;
		else if (ce)
			q <= d;
	end

	assign link.cs_n         = q.cs_n;
	assign link.sclk         = q.sclk;
	assign link.host_io_o    = q.io_o;
	assign link.host_io_oe_n = q.oe_n;
	assign prdata            = q.prdata;
	assign pready            = q.pready;
	assign pslverr           = q.pslverr;

endmodule // frrpr_host

/* File: tb/frrpr_asserts.sv */
// concurrent checks on the serial link and the device status flags
`timescale 1ns/10ps
module frrpr_asserts (
	input logic       clk,
	input logic       rst_n,
	input logic       cs_n,
	input logic       sclk,
	input logic [3:0] host_io_oe_n,
	input logic [3:0] dev_io_oe_n,
	input logic       busy_flag,
	input logic       erase_suspended_flag,
	input logic       program_suspended_flag,
	input logic       write_latch_flag,
	input logic       write_done
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// device drives the output line only
	property p_dev_lines;
		dev_io_oe_n[0] && dev_io_oe_n[3:2] == 2'b11;
	endproperty
	a_dev_lines: assert property (p_dev_lines) else $error("device drives a wrong line");

	property p_release;
		cs_n [*6] |-> dev_io_oe_n[1];
	endproperty
	a_release: assert property (p_release) else $error("data drive kept after deselect");

	property p_no_contend;
		!dev_io_oe_n[1] |-> host_io_oe_n[1];
	endproperty
	a_no_contend: assert property (p_no_contend) else $error("both ends drive output line");

	property p_sclk_idle;
		cs_n |-> !sclk;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("link clock high while deselected");

	property p_sclk_half;
		$rose(sclk) |-> sclk [*4] ##1 !sclk;
	endproperty
	a_sclk_half: assert property (p_sclk_half) else $error("link clock high phase wrong");

	property p_cs_gap;
		$rose(cs_n) |-> cs_n [*8];
	endproperty
	a_cs_gap: assert property (p_cs_gap) else $error("chip select high time too short");

	property p_one_susp;
		!(erase_suspended_flag && program_suspended_flag);
	endproperty
	a_one_susp: assert property (p_one_susp) else $error("both suspend flags set");

	property p_resume_busy;
		$fell(erase_suspended_flag || program_suspended_flag) |-> ##[0:1] busy_flag;
	endproperty
	a_resume_busy: assert property (p_resume_busy) else $error("suspend left without busy");

	property p_susp_latch;
		$rose(erase_suspended_flag || program_suspended_flag) |-> !write_latch_flag && !busy_flag;
	endproperty
	a_susp_latch: assert property (p_susp_latch) else $error("suspend kept latch or busy");

	property p_done;
		write_done |-> !erase_suspended_flag && !program_suspended_flag;
	endproperty
	a_done: assert property (p_done) else $error("write completed while suspended");

	c_erase_resume: cover property ($fell(erase_suspended_flag));
	c_prog_susp: cover property ($rose(program_suspended_flag));
	c_table_data: cover property (!dev_io_oe_n[1]);
	c_done: cover property (write_done);
endmodule // frrpr_asserts

/* File: tb/flash_resume_reset_param_read_test.sv */
// self-checking bench joining controller and device over the link
`timescale 1ns/10ps
module flash_resume_reset_param_read_test;
	localparam int OPC   = 400;
	localparam int RIDLE = 60;
	localparam int RWR   = 90;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, last_rd;
	logic [6:0]  kin;
	logic        busy_flag, erase_suspended_flag, program_suspended_flag, write_latch_flag;
	logic        quad_command_mode, perf_mode, write_done;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	int          bad_count, checked, run, busy_len, done_cnt, n;
	logic [7:0]  tab [0:23] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff,
		8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff,
		frrpr_pkg::VENDOR_ID, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hff};

	frrpr_link_if link_if();
	frrpr_host #(.SCLK_HALF_CYC(frrpr_pkg::SCLK_HALF_CYC), .RESUME_GAP_CYC(50),
		.RECOVERY_CYC(RWR)) frrpr_host_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
	frrpr_device #(.OP_CYC(OPC), .RECOV_IDLE_CYC(RIDLE), .RECOV_WRITE_CYC(RWR))
		frrpr_device_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(link_if),
		.start_erase(kin[0]), .start_program(kin[1]), .suspend(kin[2]),
		.quad_enter(kin[3]), .quad_exit(kin[4]), .perf_enter(kin[5]), .perf_exit(kin[6]),
		.busy_flag(busy_flag), .erase_suspended_flag(erase_suspended_flag),
		.program_suspended_flag(program_suspended_flag), .write_latch_flag(write_latch_flag),
		.quad_command_mode(quad_command_mode), .perf_mode(perf_mode), .write_done(write_done));
	frrpr_asserts frrpr_asserts_inst (.clk(clk), .rst_n(rst_n), .cs_n(link_if.cs_n),
		.sclk(link_if.sclk), .host_io_oe_n(link_if.host_io_oe_n),
		.dev_io_oe_n(link_if.dev_io_oe_n), .busy_flag(busy_flag),
		.erase_suspended_flag(erase_suspended_flag),
		.program_suspended_flag(program_suspended_flag),
		.write_latch_flag(write_latch_flag), .write_done(write_done));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic cmp_word(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		cmp_word({32'h0, got}, {32'h0, exp});
	endtask

	task automatic close_out;
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// x holds {compare, error, data}
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [33:0] x);
		exp_q.push_back(x);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		last_rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 34'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] x);
		apb(1'b0, a, 32'h0, {1'b1, x});
	endtask

	task automatic idle_wait;
		int k;
		k = 0;
		do begin
			apb(1'b0, frrpr_pkg::REG_STATUS, 32'h0, 34'h0);
			k++;
		end while (last_rd[1:0] !== 2'b00 && k < 300);
		cmp_bit(k < 300, 1'b1);
	endtask

	task automatic send(input logic [7:0] op, input logic q);
		wr(frrpr_pkg::REG_CMD, {23'h0, q, op});
		idle_wait;
	endtask

	task automatic kick(input int b);
		@(posedge clk);
		kin[b] <= 1'b1;
		@(posedge clk);
		kin <= 7'h0;
		repeat (3) @(posedge clk);
	endtask

	function automatic logic [7:0] tbyte(input int a);
		return a < 24 ? tab[a] : 8'hff;
	endfunction

	task automatic tread(input int a);
		wr(frrpr_pkg::REG_ADDR, a);
		wr(frrpr_pkg::REG_CMD, 32'h200 | frrpr_pkg::OP_TABLE_READ);
		idle_wait;
		rd(frrpr_pkg::REG_RDATA, {1'b0, tbyte(a + 3), tbyte(a + 2), tbyte(a + 1), tbyte(a)});
	endtask

	// result watcher: oldest note against each completed transfer
	always @(posedge clk) begin
		if (psel && penable && pready && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (e[33])
				cmp_word({pslverr, pwrite ? 32'h0 : prdata}, e[32:0]);
		end
		if (write_done === 1'b1)
			done_cnt++;
		if (busy_flag === 1'b1) begin
			run++;
		end else begin
			if (run > 0)
				busy_len = run;
			run = 0;
		end
	end

	initial begin
		#400000;
		bad_count++;
		close_out;
	end

	initial begin
		void'($urandom(32'h3f61));
		{rst_n, psel, penable, pwrite, paddr, pwdata, kin} = '0;
		{bad_count, checked, run, busy_len, done_cnt} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(frrpr_pkg::REG_STATUS, 33'h0);
		rd(8'h10, {1'b1, 32'h0});
		for (int i = 0; i < 6; i++)
			tread(i * 4);
		repeat (4) tread($urandom % 28);
		wr(frrpr_pkg::REG_CMD, {24'h0, frrpr_pkg::OP_NOP});
		apb(1'b1, frrpr_pkg::REG_CMD, 32'h30, {2'b11, 32'h0});
		idle_wait;
		rd(frrpr_pkg::REG_CMD, 33'h0);
		for (int k = 0; k < 2; k++) begin
			if (k == 1)
				kick(3);
			send(frrpr_pkg::OP_WRITE_LATCH_SET, k[0]);
			cmp_bit(write_latch_flag, 1'b1);
			kick(k);
			kick(2);
			cmp_bit(k ? program_suspended_flag : erase_suspended_flag, 1'b1);
			cmp_bit(write_latch_flag | busy_flag, 1'b0);
			if (k == 1) begin
				kick(5);
				send(frrpr_pkg::OP_RESUME, 1'b1);
				cmp_bit(program_suspended_flag, 1'b1);
				kick(6);
			end
			send(frrpr_pkg::OP_RESUME, k[0]);
			cmp_bit(erase_suspended_flag | program_suspended_flag, 1'b0);
			cmp_bit(busy_flag, 1'b1);
			n = done_cnt;
			repeat (OPC) @(posedge clk);
			cmp_bit(done_cnt == n + 1 && busy_flag === 1'b0, 1'b1);
			if (k == 1)
				kick(4);
		end
		kick(5);
		send(frrpr_pkg::OP_RESET_ARM, 1'b0);
		send(frrpr_pkg::OP_NOP, 1'b0);
		send(frrpr_pkg::OP_RESET, 1'b0);
		cmp_bit(perf_mode, 1'b1);
		kick(3);
		send(frrpr_pkg::OP_RESET_ARM, 1'b1);
		send(frrpr_pkg::OP_RESET, 1'b1);
		cmp_bit(perf_mode | quad_command_mode, 1'b0);
		cmp_bit(busy_len >= RIDLE && busy_len < RIDLE + 3, 1'b1);
		send(frrpr_pkg::OP_WRITE_LATCH_SET, 1'b0);
		kick(0);
		n = done_cnt;
		send(frrpr_pkg::OP_RESET_ARM, 1'b0);
		send(frrpr_pkg::OP_RESET, 1'b0);
		repeat (OPC) @(posedge clk);
		cmp_bit(done_cnt == n && busy_flag === 1'b0 && write_latch_flag === 1'b0, 1'b1);
		cmp_bit(busy_len >= RWR, 1'b1);
		// reset while suspended: longer recovery, flags cleared
		send(frrpr_pkg::OP_WRITE_LATCH_SET, 1'b0);
		kick(0);
		kick(2);
		cmp_bit(erase_suspended_flag, 1'b1);
		send(frrpr_pkg::OP_RESET_ARM, 1'b0);
		send(frrpr_pkg::OP_RESET, 1'b0);
		repeat (8) @(posedge clk);
		cmp_bit(erase_suspended_flag | write_latch_flag | busy_flag, 1'b0);
		cmp_bit(busy_len >= RWR && busy_len < RWR + 3, 1'b1);
		close_out;
	end
endmodule // flash_resume_reset_param_read_test
